// File: design/rsc_top.sv
`timescale 1ns/1ps
module rsc_top
	import rsc_pkg::*;
#(
	parameter int unsigned QUAL_CYCLES = QUALIFY_CYCLES
) (
	// Clock and power-on reset
	input  wire logic                  CLK,
	input  wire logic                  RESET_N,
	// Slow RC clock, sampled as a level
	input  wire logic                  SLOW_RC,
	// Supply monitor and core status
	input  wire logic                  SUPPLY_LOW,
	input  wire logic                  POWER_DOWN,
	input  wire logic                  IDLE_MODE,
	input  wire logic                  WDT_TIMEOUT,
	// Core reset controls
	output rsc_pkg::rsc_core_ctl_t     CORE_CTL,
	output logic [1:0]                 THRESHOLD_SEL,
	output logic                       TIMEOUT_FLAG,
	output logic                       POWERDOWN_FLAG,
	// AXI4-Lite slave
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [rsc_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	output logic [1:0]                 S_AXI_BRESP,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	input  wire logic [rsc_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP
);

	import rsc_pkg::*;

	rsc_state_t st;
	rsc_state_t next_st;
	logic       slow_edge;
	logic       sleeping;
	logic       thr_bad;
	logic       wdog_bad;
	logic       brown_req;
	logic       fire;
	logic       release_ok;
	logic       do_write;
	logic [7:0] flags_rd;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic thr_valid(input logic [7:0] code);
		thr_valid = (code == THR_LOWEST) || (code == THR_LOW) ||
			(code == THR_HIGH) || (code == THR_HIGHEST);
	endfunction : thr_valid

	assign slow_edge = SLOW_RC & ~st.prev_slow;
	assign sleeping  = POWER_DOWN | IDLE_MODE;
	assign thr_bad   = ~thr_valid(st.thr);
	assign wdog_bad  = (st.wdog[7:3] != WDOG_EN_A) && (st.wdog[7:3] != WDOG_EN_B);
	// Low supply must outlast the qualify count before it counts as real
	assign brown_req = SUPPLY_LOW && !POWER_DOWN &&
		(st.qual_cnt == QUAL_CYCLES[QUAL_W-1:0]);
	assign fire = (st.phase == PH_WAIT) && slow_edge &&
		(st.edge_cnt == EDGE_W'(SLOW_EDGES - 1));
	// A brownout reset is held for as long as the supply stays low, unless power-down is active
	assign release_ok = slow_edge && (st.edge_cnt == EDGE_W'(HOLD_EDGES - 1)) &&
		!(st.cause == CA_BROWNOUT && SUPPLY_LOW && !POWER_DOWN);
	assign do_write = st.aw_got && st.w_got && !st.bvalid;
	assign flags_rd = {st.fsys_keep, 4'h0, st.brownout_flag, st.thr_fault_flag,
		st.wdog_fault_flag};

	always_comb begin
		case (st.thr)
			THR_LOW:     THRESHOLD_SEL = 2'h1;
			THR_HIGH:    THRESHOLD_SEL = 2'h2;
			THR_HIGHEST: THRESHOLD_SEL = 2'h3;
			default:     THRESHOLD_SEL = 2'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st = st;
		next_st.prev_slow = SLOW_RC;
		next_st.prev_pd   = POWER_DOWN;

		// Qualify counter restarts on every recovery, so glitches leave no trace
		if (!SUPPLY_LOW || POWER_DOWN) begin
			next_st.qual_cnt = '0;
		end else if (st.qual_cnt != QUAL_CYCLES[QUAL_W-1:0]) begin
			next_st.qual_cnt = st.qual_cnt + QUAL_W'(1);
		end

		// Register writes first so hardware sets below win over a clear
		if (do_write && st.wstrb0) begin
			if (st.awaddr == OFS_THRESH) begin
				next_st.thr = st.wdata;
			end else if (st.awaddr == OFS_FLAGS) begin
				next_st.fsys_keep       = st.wdata[FLG_FSYS];
				next_st.brownout_flag   = st.wdata[FLG_BROWN];
				next_st.thr_fault_flag  = st.wdata[FLG_THR];
				next_st.wdog_fault_flag = st.wdata[FLG_WDOG];
			end else if (st.awaddr == OFS_WDOG) begin
				next_st.wdog = st.wdata;
			end else if (st.awaddr == OFS_STATUS) begin
				next_st.timeout_flag   = st.timeout_flag & st.wdata[ST_TIMEOUT];
				next_st.powerdown_flag = st.powerdown_flag & st.wdata[ST_PDOWN];
			end
		end

		// Entering power-down marks the power-down flag, even against a clear
		if (POWER_DOWN && !st.prev_pd) begin
			next_st.powerdown_flag = 1'b1;
		end

		case (st.phase)
			PH_IDLE: begin
				next_st.edge_cnt = '0;
				if (thr_bad) begin
					next_st.phase = PH_WAIT;
					next_st.cause = CA_THR_CODE;
				end else if (wdog_bad) begin
					next_st.phase = PH_WAIT;
					next_st.cause = CA_WDOG_CODE;
				end else if (brown_req) begin
					next_st.phase = PH_WAIT;
					next_st.cause = CA_BROWNOUT;
				end else if (WDT_TIMEOUT) begin
					next_st.phase = PH_WAIT;
					next_st.cause = sleeping ? CA_WDT_SLEEP : CA_WDT_RUN;
				end
			end
			PH_WAIT: begin
				if (slow_edge) begin
					next_st.edge_cnt = st.edge_cnt + EDGE_W'(1);
				end
				if (fire) begin
					next_st.phase    = PH_ACTIVE;
					next_st.edge_cnt = '0;
					case (st.cause)
						CA_BROWNOUT: begin
							next_st.brownout_flag = 1'b1;
							next_st.wdog = WDOG_POR;
						end
						CA_THR_CODE: begin
							next_st.thr_fault_flag = 1'b1;
							next_st.thr  = THR_POR;
							next_st.wdog = WDOG_POR;
						end
						CA_WDOG_CODE: begin
							next_st.wdog_fault_flag = 1'b1;
							next_st.wdog = WDOG_POR;
						end
						CA_WDT_RUN: begin
							next_st.timeout_flag = 1'b1;
							next_st.wdog = WDOG_POR;
						end
						default: begin
							next_st.timeout_flag   = 1'b1;
							next_st.powerdown_flag = 1'b1;
						end
					endcase
				end
			end
			PH_ACTIVE: begin
				if (slow_edge && st.edge_cnt != EDGE_W'(HOLD_EDGES - 1)) begin
					next_st.edge_cnt = st.edge_cnt + EDGE_W'(1);
				end
				if (release_ok) begin
					next_st.phase    = PH_IDLE;
					next_st.edge_cnt = '0;
				end
			end
			default: begin
				next_st.phase = PH_IDLE;
			end
		endcase

		// Core controls; a sleep timeout touches only PC and SP
		next_st.ctl.pc_sp_clear = (next_st.phase == PH_ACTIVE);
		next_st.ctl.full_reset  = (next_st.phase == PH_ACTIVE) &&
			(next_st.cause != CA_WDT_SLEEP);
		next_st.ctl.wdt_clear      = next_st.ctl.full_reset;
		next_st.ctl.irq_disable    = next_st.ctl.full_reset;
		next_st.ctl.timers_off     = next_st.ctl.full_reset;
		next_st.ctl.ports_all_ones = next_st.ctl.full_reset;
		next_st.ctl.analog_to_adc  = next_st.ctl.full_reset;
		next_st.ctl.stack_top      = next_st.ctl.full_reset;

		// AXI4-Lite write path
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_st.w_got  = 1'b1;
			next_st.wdata  = S_AXI_WDATA[7:0];
			next_st.wstrb0 = S_AXI_WSTRB[0];
		end
		if (do_write) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = (st.awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
		end else if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end

		// AXI4-Lite read path
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			if (S_AXI_ARADDR == OFS_THRESH) begin
				next_st.rdata = {24'h0, st.thr};
			end else if (S_AXI_ARADDR == OFS_FLAGS) begin
				next_st.rdata = {24'h0, flags_rd};
			end else if (S_AXI_ARADDR == OFS_WDOG) begin
				next_st.rdata = {24'h0, st.wdog};
			end else if (S_AXI_ARADDR == OFS_STATUS) begin
				next_st.rdata = {29'h0, st.ctl.full_reset, st.powerdown_flag,
					st.timeout_flag};
			end else begin
				next_st.rdata = 32'h0;
				next_st.rresp = RESP_SLVERR;
			end
		end else if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st                 <= '0;
			st.phase           <= PH_ACTIVE;
			st.cause           <= CA_POR;
			st.thr             <= THR_POR;
			st.wdog            <= WDOG_POR;
			st.ctl             <= '1;
			st.bresp           <= RESP_OKAY;
			st.rresp           <= RESP_OKAY;
		end else begin
			st <= next_st;
		end
	end

	assign CORE_CTL       = st.ctl;
	assign TIMEOUT_FLAG   = st.timeout_flag;
	assign POWERDOWN_FLAG = st.powerdown_flag;
	assign S_AXI_AWREADY  = !st.aw_got && !st.bvalid;
	assign S_AXI_WREADY   = !st.w_got && !st.bvalid;
	assign S_AXI_BVALID   = st.bvalid;
	assign S_AXI_BRESP    = st.bresp;
	assign S_AXI_ARREADY  = !st.rvalid;
	assign S_AXI_RVALID   = st.rvalid;
	assign S_AXI_RDATA    = st.rdata;
	assign S_AXI_RRESP    = st.rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_brown_qualified: assert property (@(posedge CLK) disable iff (!RESET_N)
		(st.phase == PH_IDLE && next_st.cause == CA_BROWNOUT && next_st.phase == PH_WAIT)
		|-> (st.qual_cnt == QUAL_CYCLES[QUAL_W-1:0]) && SUPPLY_LOW)
		else $error("brownout accepted before qualify time");

	a_brown_keeps_thr: assert property (@(posedge CLK) disable iff (!RESET_N)
		(fire && st.cause == CA_BROWNOUT)
		|=> st.brownout_flag && (st.thr == $past(st.thr)) && st.ctl.full_reset)
		else $error("brownout reset changed threshold or missed flag");

	a_bad_thr_restore: assert property (@(posedge CLK) disable iff (!RESET_N)
		(fire && st.cause == CA_THR_CODE)
		|=> (st.thr == THR_POR) && st.thr_fault_flag && st.ctl.full_reset)
		else $error("bad threshold code not restored");

	a_pdown_no_brown: assert property (@(posedge CLK) disable iff (!RESET_N)
		POWER_DOWN |=> (st.qual_cnt == '0))
		else $error("brownout qualify ran in power-down");

	a_slow_delay: assert property (@(posedge CLK) disable iff (!RESET_N)
		(st.phase == PH_WAIT) |=> (st.ctl.pc_sp_clear == $past(fire)) &&
		(st.phase == ($past(fire) ? PH_ACTIVE : PH_WAIT)))
		else $error("reset reached core without slow-edge wait");

	a_sleep_wdt: assert property (@(posedge CLK) disable iff (!RESET_N)
		(fire && st.cause == CA_WDT_SLEEP)
		|=> st.timeout_flag && st.powerdown_flag && st.ctl.pc_sp_clear && !st.ctl.full_reset)
		else $error("sleep timeout did more than PC and SP clear");

	a_run_wdt: assert property (@(posedge CLK) disable iff (!RESET_N)
		(fire && st.cause == CA_WDT_RUN)
		|=> st.timeout_flag && st.ctl.full_reset && (st.powerdown_flag == $past(st.powerdown_flag)))
		else $error("running timeout reset wrong");

	a_wdog_code: assert property (@(posedge CLK) disable iff (!RESET_N)
		(fire && st.cause == CA_WDOG_CODE) |=> st.wdog_fault_flag && (st.wdog == WDOG_POR))
		else $error("bad watchdog code reset wrong");

	a_full_ctl: assert property (@(posedge CLK) disable iff (!RESET_N)
		CORE_CTL.full_reset |-> CORE_CTL.ports_all_ones && CORE_CTL.stack_top &&
		CORE_CTL.irq_disable && CORE_CTL.timers_off && CORE_CTL.analog_to_adc)
		else $error("full reset missing a core control");

	a_flags_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
		(S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == OFS_FLAGS)
		|=> S_AXI_RVALID && (S_AXI_RDATA[6:3] == 4'h0))
		else $error("unimplemented flag bits read nonzero");

	c_brownout: cover property (@(posedge CLK) disable iff (!RESET_N)
		fire && st.cause == CA_BROWNOUT);
	c_bad_thr: cover property (@(posedge CLK) disable iff (!RESET_N)
		fire && st.cause == CA_THR_CODE);
	c_sleep_wdt: cover property (@(posedge CLK) disable iff (!RESET_N)
		fire && st.cause == CA_WDT_SLEEP);
	c_glitch: cover property (@(posedge CLK) disable iff (!RESET_N)
		SUPPLY_LOW ##1 !SUPPLY_LOW && st.phase == PH_IDLE);

endmodule : rsc_top

// File: include/rsc_pkg.sv
package rsc_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned QUALIFY_NS     = 100000;
	localparam int unsigned QUALIFY_CYCLES = (QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned QUAL_W         = 12;
	localparam int unsigned SLOW_EDGES     = 2;
	localparam int unsigned HOLD_EDGES     = 4;
	localparam int unsigned EDGE_W         = 3;

	// Register map, byte addresses
	localparam int unsigned AXI_AW       = 4;
	localparam logic [3:0]  OFS_THRESH   = 4'h0;
	localparam logic [3:0]  OFS_FLAGS    = 4'h4;
	localparam logic [3:0]  OFS_WDOG     = 4'h8;
	localparam logic [3:0]  OFS_STATUS   = 4'hc;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Threshold codes and reset values
	localparam logic [7:0] THR_LOWEST  = 8'h55;
	localparam logic [7:0] THR_LOW     = 8'h33;
	localparam logic [7:0] THR_HIGH    = 8'h99;
	localparam logic [7:0] THR_HIGHEST = 8'haa;
	localparam logic [7:0] THR_POR     = 8'h55;
	localparam logic [7:0] WDOG_POR    = 8'h53;
	localparam logic [4:0] WDOG_EN_A   = 5'h0a;
	localparam logic [4:0] WDOG_EN_B   = 5'h15;

	// Reset cause flag bit positions
	localparam int unsigned FLG_WDOG   = 0;
	localparam int unsigned FLG_THR    = 1;
	localparam int unsigned FLG_BROWN  = 2;
	localparam int unsigned FLG_FSYS   = 7;
	localparam int unsigned ST_TIMEOUT = 0;
	localparam int unsigned ST_PDOWN   = 1;
	localparam int unsigned ST_FULL    = 2;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'h0,
		PH_WAIT   = 2'h1,
		PH_ACTIVE = 2'h3
	} rsc_phase_t;

	typedef enum logic [2:0] {
		CA_POR       = 3'h0,
		CA_BROWNOUT  = 3'h1,
		CA_THR_CODE  = 3'h2,
		CA_WDOG_CODE = 3'h3,
		CA_WDT_RUN   = 3'h4,
		CA_WDT_SLEEP = 3'h5
	} rsc_cause_t;

	typedef struct packed {
		logic full_reset;
		logic pc_sp_clear;
		logic wdt_clear;
		logic irq_disable;
		logic timers_off;
		logic ports_all_ones;
		logic analog_to_adc;
		logic stack_top;
	} rsc_core_ctl_t;

	typedef struct packed {
		logic               prev_slow;
		logic               prev_pd;
		logic [QUAL_W-1:0]  qual_cnt;
		rsc_phase_t         phase;
		rsc_cause_t         cause;
		logic [EDGE_W-1:0]  edge_cnt;
		logic [7:0]         thr;
		logic [7:0]         wdog;
		logic               fsys_keep;
		logic               brownout_flag;
		logic               thr_fault_flag;
		logic               wdog_fault_flag;
		logic               timeout_flag;
		logic               powerdown_flag;
		rsc_core_ctl_t      ctl;
		logic               aw_got;
		logic [AXI_AW-1:0]  awaddr;
		logic               w_got;
		logic [7:0]         wdata;
		logic               wstrb0;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} rsc_state_t;

endpackage : rsc_pkg

// File: test/rsc_far_model.sv
`timescale 1ns/1ps
module rsc_far_model
	import rsc_pkg::*;
#(
	parameter int unsigned SLOW_HALF = 4
) (
	// Clock
	input  wire logic                 clk,
	// Bench commands
	input  wire logic                 low_req,
	input  wire logic                 pd_req,
	input  wire logic                 idle_req,
	input  wire logic                 wdt_req,
	// Reset controls as the core sees them
	input  wire rsc_pkg::rsc_core_ctl_t core_ctl,
	// Toward the block
	output logic                      slow_rc     = 1'b0,
	output logic                      supply_low  = 1'b0,
	output logic                      power_down  = 1'b0,
	output logic                      idle_mode   = 1'b0,
	output logic                      wdt_timeout = 1'b0
);
	int unsigned cnt = 0;

	////////////////////////////////////////////////////////////////////////////
	// The RC oscillator runs free; a larger SLOW_HALF models a slow part
	always @(posedge clk) begin
		cnt         <= (cnt == 2 * SLOW_HALF - 1) ? 0 : cnt + 1;
		slow_rc     <= (cnt < SLOW_HALF);
		supply_low  <= low_req;
		// A full reset wakes the core, so sleep and idle end with it
		power_down  <= pd_req & ~core_ctl.full_reset;
		idle_mode   <= idle_req & ~core_ctl.full_reset;
		wdt_timeout <= wdt_req;
	end
endmodule : rsc_far_model

// File: test/reset_source_control_tb_top.sv
`timescale 1ns/1ps
module reset_source_control_tb_top;
	import rsc_pkg::*;
	localparam int unsigned QC = 5;
	// One to two slow periods of 8 clocks, plus register slack
	localparam int HI = 28;
	logic          clk, reset_n, low_req, pd_req, idle_req, wdt_req;
	logic          slow_rc, supply_low, power_down, idle_mode, wdt_timeout;
	rsc_core_ctl_t core_ctl;
	logic [1:0]    thr_sel, bresp, rresp, r;
	logic          to_flag, pd_flag, bvalid, bready, rvalid, rready;
	logic          awvalid, awready, wvalid, wready, arvalid, arready;
	logic [3:0]    awaddr, araddr, wstrb;
	logic [31:0]   wdata, rdata, v;
	logic [7:0]    codes [4] = '{THR_LOWEST, THR_LOW, THR_HIGH, THR_HIGHEST};
	int            miscompares = 0;
	int            n_checks = 0;

	rsc_top #(.QUAL_CYCLES(QC)) u_rsc_top (
		.CLK(clk), .RESET_N(reset_n), .SLOW_RC(slow_rc), .SUPPLY_LOW(supply_low),
		.POWER_DOWN(power_down), .IDLE_MODE(idle_mode), .WDT_TIMEOUT(wdt_timeout),
		.CORE_CTL(core_ctl), .THRESHOLD_SEL(thr_sel), .TIMEOUT_FLAG(to_flag),
		.POWERDOWN_FLAG(pd_flag), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));

	rsc_far_model #(.SLOW_HALF(4)) u_rsc_far_model (
		.clk(clk), .low_req(low_req), .pd_req(pd_req), .idle_req(idle_req),
		.wdt_req(wdt_req), .core_ctl(core_ctl), .slow_rc(slow_rc),
		.supply_low(supply_low), .power_down(power_down), .idle_mode(idle_mode),
		.wdt_timeout(wdt_timeout));

	////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic stall(input string nm);
		miscompares++;
		$display("[ERR] %s expected done seen timeout", nm);
		results();
	endtask : stall

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_in(input string nm, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_in

	////////////////////////////////////////////////////////////////////////////
	// Bus tasks start and end just after a rising edge; ready lines stay high
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (n > 50) stall("write");
		end while (!bvalid);
		rs = bresp;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		arvalid <= 1'b1;
		araddr  <= a;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (n > 50) stall("read");
		end while (!rvalid);
		d  = rdata;
		rs = rresp;
	endtask : rd

	task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		chk(nm, e, d);
		chk("read resp", {30'h0, RESP_OKAY}, {30'h0, rs});
	endtask : rdchk

	task automatic wait_rst(input int hi);
		int n;
		n = 0;
		while (core_ctl === 8'h00) begin
			@(posedge clk);
			n++;
			if (n > 200) stall("reset");
		end
		chk_in("reset delay", 6, hi, n);
	endtask : wait_rst

	task automatic wait_rel;
		int n;
		n = 0;
		while (core_ctl !== 8'h00) begin
			@(posedge clk);
			n++;
			if (n > 300) stall("release");
		end
	endtask : wait_rel

	task automatic quiet(input int cyc);
		logic bad;
		bad = 1'b0;
		repeat (cyc) begin
			@(posedge clk);
			if (core_ctl !== 8'h00) bad = 1'b1;
		end
		chk("no reset", 32'h0, {31'h0, bad});
	endtask : quiet

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		reset_n = 0; low_req = 0; pd_req = 0; idle_req = 0; wdt_req = 0;
		awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
		awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h1;
		repeat (3) @(posedge clk);
		chk("por ctl", 32'hff, {24'h0, core_ctl});
		reset_n <= 1'b1;
		@(posedge clk);
		wait_rel;
		rdchk(OFS_THRESH, {24'h0, THR_POR}, "thresh");
		rdchk(OFS_FLAGS, 32'h0, "flags");
		rdchk(OFS_WDOG, {24'h0, WDOG_POR}, "wdog");
		rdchk(OFS_STATUS, 32'h0, "status");
		$display("test por done");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_THRESH, codes[i], r);
			chk("thr sel", 32'(i), {30'h0, thr_sel});
		end
		$display("test codes done");
		wr(OFS_THRESH, 8'h00, r);
		wait_rst(HI);
		wait_rel;
		rdchk(OFS_THRESH, {24'h0, THR_POR}, "thresh");
		rdchk(OFS_FLAGS, 32'h2, "flags");
		wr(OFS_FLAGS, 8'h00, r);
		rdchk(OFS_FLAGS, 32'h0, "flags");
		wr(OFS_WDOG, 8'h00, r);
		wait_rst(HI);
		wait_rel;
		rdchk(OFS_WDOG, {24'h0, WDOG_POR}, "wdog");
		rdchk(OFS_FLAGS, 32'h1, "flags");
		wr(OFS_FLAGS, 8'h00, r);
		rdchk(OFS_FLAGS, 32'h0, "flags");
		$display("test bad codes done");
		wr(OFS_THRESH, THR_HIGHEST, r);
		// Shorter than the qualify time
		low_req <= 1'b1;
		repeat (QC - 2) @(posedge clk);
		low_req <= 1'b0;
		quiet(40);
		rdchk(OFS_FLAGS, 32'h0, "flags");
		pd_req <= 1'b1;
		@(posedge clk);
		low_req <= 1'b1;
		quiet(40);
		low_req <= 1'b0;
		pd_req  <= 1'b0;
		@(posedge clk);
		rdchk(OFS_STATUS, 32'h2, "status");
		low_req <= 1'b1;
		wait_rst(HI + QC);
		low_req <= 1'b0;
		wait_rel;
		rdchk(OFS_THRESH, {24'h0, THR_HIGHEST}, "thresh");
		rdchk(OFS_FLAGS, 32'h4, "flags");
		rdchk(OFS_STATUS, 32'h2, "status");
		wr(OFS_FLAGS, 8'h00, r);
		rdchk(OFS_FLAGS, 32'h0, "flags");
		$display("test brownout done");
		wdt_req <= 1'b1;
		@(posedge clk);
		wdt_req <= 1'b0;
		wait_rst(HI);
		chk("wdt ctl", 32'hff, {24'h0, core_ctl});
		wait_rel;
		rdchk(OFS_STATUS, 32'h3, "status");
		chk("flag pins", 32'h3, {30'h0, pd_flag, to_flag});
		wr(OFS_STATUS, 8'h00, r);
		for (int i = 0; i < 2; i++) begin
			pd_req   <= (i == 0);
			idle_req <= (i == 1);
			repeat (3) @(posedge clk);
			wdt_req <= 1'b1;
			@(posedge clk);
			wdt_req <= 1'b0;
			wait_rst(HI);
			chk("sleep ctl", 32'h40, {24'h0, core_ctl});
			pd_req   <= 1'b0;
			idle_req <= 1'b0;
			wait_rel;
			rdchk(OFS_STATUS, 32'h3, "status");
			chk("flag pins", 32'h3, {30'h0, pd_flag, to_flag});
			wr(OFS_STATUS, 8'h00, r);
		end
		$display("test watchdog done");
		wr(4'h2, 8'h00, r);
		chk("unaligned wr", {30'h0, RESP_SLVERR}, {30'h0, r});
		rd(4'h1, v, r);
		chk("unaligned rd", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unaligned data", 32'h0, v);
		wr(OFS_FLAGS, 8'hf8, r);
		rdchk(OFS_FLAGS, 32'h80, "flags");
		$display("test bus done");
		results();
	end
endmodule : reset_source_control_tb_top
